// File: include/hrp_pkg.sv
package hrp_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          NUM_SRC         = 7;
  localparam int          NUM_REG         = 4;
  // normal register map (test space bit low)
  localparam logic [6:0]  OFF_MASK        = 7'h00;
  localparam logic [6:0]  OFF_STATUS      = 7'h01;
  localparam logic [6:0]  OFF_SCRATCH     = 7'h02;
  localparam logic [6:0]  OFF_ID          = 7'h03;
  // test register map (test space bit high)
  localparam logic [6:0]  OFF_TEST_FORCE  = 7'h00;
  localparam logic [7:0]  RST_MASK        = 8'h00;
  localparam logic [7:0]  RST_SCRATCH     = 8'h00;
  // identity value is arbitrary
  localparam logic [7:0]  ID_VALUE        = 8'h5A;
  // alarm source bit positions
  localparam int          SRC_LOS         = 0;
  localparam int          SRC_LOF         = 1;
  localparam int          SRC_LINE_AIS    = 2;
  localparam int          SRC_LINE_FERF   = 3;
  localparam int          SRC_LOP         = 4;
  localparam int          SRC_PATH_AIS    = 5;
  localparam int          SRC_PATH_YEL    = 6;
  // host strobe timing in system clocks
  localparam int          SETUP_CYC       = 2;
  localparam int          STROBE_CYC      = 3;
  localparam int          HOLD_CYC        = 2;
  typedef enum logic [2:0] {
    H_IDLE   = 3'b000,
    H_ALE    = 3'b001,
    H_SETUP  = 3'b011,
    H_STROBE = 3'b010,
    H_HOLD   = 3'b110
  } host_state_t;
endpackage : hrp_pkg

// File: include/hrp_if.sv
`timescale 1ns/100ps
interface hrp_if;
  logic [7:0] addr;
  logic       latch_en;
  logic       chip_select_n;
  logic       read_strobe_n;
  logic       write_strobe_n;
  logic [7:0] data_host;
  logic       data_host_oe;
  logic [7:0] data_dev;
  logic       data_dev_oe;
  logic       irq_out_n;
  logic       irq_oe;
  logic       chip_reset_n;
  // resolved shared wires, pulls applied
  wire  [7:0] data_bus = data_dev_oe ? data_dev : (data_host_oe ? data_host : 8'hFF);
  wire        irq_line = irq_oe ? 1'b0 : 1'b1;

  modport device (
    input  addr, latch_en, chip_select_n, read_strobe_n, write_strobe_n, data_bus, chip_reset_n,
    output data_dev, data_dev_oe, irq_out_n, irq_oe
  );
  modport host (
    output addr, latch_en, chip_select_n, read_strobe_n, write_strobe_n, data_host, data_host_oe,
    output chip_reset_n,
    input  data_bus, irq_line
  );
endinterface : hrp_if

// File: verilog/hrp_device.sv
`timescale 1ns/100ps
module hrp_device
  import hrp_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  hrp_if.device             bus,
  input  wire logic [6:0]   alarm_in,
  output logic      [7:0]   scratch_out
);
  logic [7:0] addr_hold;
  logic [7:0] mask;
  logic [6:0] status;
  logic [6:0] force_src;
  logic [7:0] scratch;
  logic       wr_d;
  logic       rd_d;
  logic [7:0] rd_data;
  logic       rd_oe;
  logic       irq_q;

  // reset from chip pin or system reset
  wire        dev_rst     = !rstn || !bus.chip_reset_n;
  wire [7:0]  cur_addr    = bus.latch_en ? bus.addr : addr_hold;
  wire        test_space  = cur_addr[7];
  wire [6:0]  reg_off     = cur_addr[6:0];
  wire        wr_act      = !bus.write_strobe_n && !bus.chip_select_n;
  wire        rd_act      = !bus.read_strobe_n && !bus.chip_select_n;
  wire        wr_commit   = wr_d && !wr_act;
  wire        rd_end      = rd_d && !rd_act;
  wire        sel_mask    = !test_space && reg_off == OFF_MASK;
  wire        sel_status  = !test_space && reg_off == OFF_STATUS;
  wire        sel_scratch = !test_space && reg_off == OFF_SCRATCH;
  wire        sel_id      = !test_space && reg_off == OFF_ID;
  wire        sel_force   = test_space && reg_off == OFF_TEST_FORCE;
  wire [6:0]  src_now     = alarm_in | force_src;
  wire [7:0]  next_rd     = sel_mask    ? mask :
                            sel_status  ? {1'b0, status} :
                            sel_scratch ? scratch :
                            sel_id      ? ID_VALUE :
                            sel_force   ? {1'b0, force_src} : 8'h00;
  wire        irq_pend    = |(status & mask[6:0]);

  always_ff @(posedge clk_sys) begin
    if (bus.latch_en) begin
      addr_hold <= bus.addr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (dev_rst) begin
      wr_d <= 1'b0;
      rd_d <= 1'b0;
      mask <= RST_MASK;
      scratch <= RST_SCRATCH;
      force_src <= 7'h00;
    end else begin
      wr_d <= wr_act;
      rd_d <= rd_act;
      if (wr_commit && sel_mask) begin
        mask <= bus.data_bus;
      end
      if (wr_commit && sel_scratch) begin
        scratch <= bus.data_bus;
      end
      if (wr_commit && sel_force) begin
        force_src <= bus.data_bus[6:0];
      end
    end
  end

  // sticky per-source status, clear on read, set wins
  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i++) begin : g_src
      always_ff @(posedge clk_sys) begin
        if (dev_rst) begin
          status[i] <= 1'b0;
        end else if (src_now[i]) begin
          status[i] <= 1'b1;
        end else if (rd_end && sel_status) begin
          status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (dev_rst) begin
      rd_data <= 8'h00;
      rd_oe <= 1'b0;
      irq_q <= 1'b0;
      scratch_out <= RST_SCRATCH;
    end else begin
      rd_data <= next_rd;
      rd_oe <= rd_act;
      irq_q <= irq_pend;
      scratch_out <= scratch;
    end
  end

  assign bus.data_dev    = rd_data;
  assign bus.data_dev_oe = rd_oe;
  assign bus.irq_out_n   = 1'b0;
  assign bus.irq_oe      = irq_q;
endmodule : hrp_device

// File: verilog/hrp_host.sv
`timescale 1ns/100ps
module hrp_host
  import hrp_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  hrp_if.host               bus,
  input  wire logic         req,
  input  wire logic         req_write,
  input  wire logic [7:0]   req_addr,
  input  wire logic [7:0]   req_wdata,
  output logic              busy,
  output logic              done,
  output logic [7:0]        rdata,
  output logic              irq
);
  host_state_t state;
  host_state_t next_state;
  logic [1:0]  cnt;
  logic        wr;
  logic [7:0]  wdata;
  logic [7:0]  addr_q;

  wire cnt_done = cnt == 2'd0;
  always_comb begin
    next_state = state;
    unique case (state)
      H_IDLE:   if (req) next_state = H_ALE;
      H_ALE:    next_state = H_SETUP;
      H_SETUP:  if (cnt_done) next_state = H_STROBE;
      H_STROBE: if (cnt_done) next_state = H_HOLD;
      H_HOLD:   if (cnt_done) next_state = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state <= H_IDLE;
      cnt <= 2'd0;
      wr <= 1'b0;
      wdata <= 8'h00;
      addr_q <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      irq <= 1'b0;
      bus.addr <= 8'h00;
      bus.latch_en <= 1'b1;
      bus.chip_select_n <= 1'b1;
      bus.read_strobe_n <= 1'b1;
      bus.write_strobe_n <= 1'b1;
      bus.data_host <= 8'h00;
      bus.data_host_oe <= 1'b0;
      bus.chip_reset_n <= 1'b1;
    end else begin
      state <= next_state;
      done <= 1'b0;
      irq <= !bus.irq_line;
      cnt <= cnt_done ? 2'd0 : cnt - 2'd1;
      unique case (state)
        H_IDLE: if (req) begin
          wr <= req_write;
          wdata <= req_wdata;
          addr_q <= req_addr;
          busy <= 1'b1;
          // present address, bit 7 test space
          bus.addr <= req_addr;
          bus.latch_en <= 1'b1;
        end
        H_ALE: begin
          bus.latch_en <= 1'b0;
          bus.chip_select_n <= 1'b0;
          bus.data_host <= wdata;
          bus.data_host_oe <= wr;
          cnt <= 2'(SETUP_CYC - 1);
        end
        H_SETUP: if (cnt_done) begin
          bus.read_strobe_n <= wr;
          bus.write_strobe_n <= !wr;
          cnt <= 2'(STROBE_CYC - 1);
        end
        H_STROBE: if (cnt_done) begin
          // data held past rising write edge
          bus.read_strobe_n <= 1'b1;
          bus.write_strobe_n <= 1'b1;
          if (!wr) begin
            rdata <= bus.data_bus;
          end
          cnt <= 2'(HOLD_CYC - 1);
        end
        H_HOLD: if (cnt_done) begin
          bus.chip_select_n <= 1'b1;
          bus.data_host_oe <= 1'b0;
          bus.latch_en <= 1'b1;
          bus.addr <= addr_q;
          busy <= 1'b0;
          done <= 1'b1;
        end
      endcase
    end
  end
endmodule : hrp_host

// File: bench/hrp_port_asserts.sv
`timescale 1ns/100ps
module hrp_port_asserts
  import hrp_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       latch_en,
  input wire logic       chip_select_n,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic [7:0] data_host,
  input wire logic       data_host_oe,
  input wire logic       data_dev_oe,
  input wire logic       irq_out_n,
  input wire logic       irq_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  drive_in_read_a: assert property (data_dev_oe |-> $past(!read_strobe_n && !chip_select_n))
    else $error("data bus driven outside a read");
  read_drive_a: assert property (!read_strobe_n && !chip_select_n |=> data_dev_oe)
    else $error("read not driven");
  no_contention_a: assert property (!(data_dev_oe && data_host_oe))
    else $error("both ends drive data bus");
  open_drain_a: assert property (irq_oe |-> irq_out_n == 1'b0)
    else $error("irq driven high");
  strobe_select_a: assert property (!read_strobe_n || !write_strobe_n |-> !chip_select_n && !latch_en)
    else $error("strobe without select or latch");
  latch_reopen_a: assert property ($rose(latch_en) |-> chip_select_n)
    else $error("latch opened in access");
  write_pulse_a: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*3] ##1 write_strobe_n)
    else $error("write strobe width wrong");
  write_data_a: assert property (!write_strobe_n |-> data_host_oe && $stable(data_host))
    else $error("write data not held");
  cover property ($fell(write_strobe_n));
  cover property ($fell(read_strobe_n));
  cover property ($rose(irq_oe));
endmodule : hrp_port_asserts

// File: bench/host_register_port_tb.sv
`timescale 1ns/100ps
module host_register_port_tb
  import hrp_pkg::*;
;
  logic       clk_sys, rstn, req, req_write, busy, done, irq;
  logic [7:0] req_addr, req_wdata, rdata, scratch_out, seed;
  logic [6:0] alarm_in;
  int         mismatches, n_checks, cycles, stat, mask_m;
  int         m_mask, m_scratch, m_force;
  hrp_if      bus_if ();
  hrp_device i_hrp_device (.clk_sys(clk_sys), .rstn(rstn), .bus(bus_if), .alarm_in(alarm_in),
    .scratch_out(scratch_out));
  hrp_host i_hrp_host (.clk_sys(clk_sys), .rstn(rstn), .bus(bus_if), .req(req), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata), .irq(irq));
  hrp_port_asserts i_chk (.clk_sys(clk_sys), .rstn(rstn), .latch_en(bus_if.latch_en),
    .chip_select_n(bus_if.chip_select_n), .read_strobe_n(bus_if.read_strobe_n),
    .write_strobe_n(bus_if.write_strobe_n), .data_host(bus_if.data_host), .data_host_oe(bus_if.data_host_oe),
    .data_dev_oe(bus_if.data_dev_oe), .irq_out_n(bus_if.irq_out_n), .irq_oe(bus_if.irq_oe));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task end_of_test();
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    req <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk_sys);
    req <= 1'b0;
    @(negedge clk_sys);
    chk("busy", {7'h00, busy}, 8'h01);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (done !== 1'b1 && n < 20);
    chk("done", {7'h00, done}, 8'h01);
    chk("busy", {7'h00, busy}, 8'h00);
    if (w && a == {1'b0, OFF_MASK}) m_mask = d;
    if (w && a == {1'b0, OFF_SCRATCH}) m_scratch = d;
    if (w && a == {1'b1, OFF_TEST_FORCE}) m_force = d & 'h7F;
  endtask : acc
  function automatic int model_read(input logic [7:0] a);
    case (a)
      {1'b0, OFF_MASK}:       return m_mask;
      {1'b0, OFF_STATUS}:     return stat;
      {1'b0, OFF_SCRATCH}:    return m_scratch;
      {1'b0, OFF_ID}:         return ID_VALUE;
      {1'b1, OFF_TEST_FORCE}: return m_force;
      default:                return 0;
    endcase
  endfunction : model_read
  task rd(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk($sformatf("read %h", a), rdata, exp);
    chk("model", rdata, 8'(model_read(a)));
    if (a == {1'b0, OFF_STATUS}) stat = 0;
  endtask : rd
  task ichk();
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("irq", {7'h00, irq}, {7'h00, (stat & mask_m) != 0});
  endtask : ichk
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    rstn = 1'b0;
    req = 1'b0;
    req_write = 1'b0;
    req_addr = 8'h00;
    req_wdata = 8'h00;
    alarm_in = 7'h00;
    seed = 8'h63;
    m_mask = RST_MASK;
    m_scratch = RST_SCRATCH;
    m_force = 0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(8'h03, ID_VALUE);
    rd(8'h00, RST_MASK);
    rd(8'h02, RST_SCRATCH);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      acc(1'b1, 8'h02, seed);
      chk("scratch_out", scratch_out, seed);
      rd(8'h02, seed);
    end
    acc(1'b1, 8'h82, ~seed);
    acc(1'b1, 8'h10, ~seed);
    rd(8'h10, 8'h00);
    rd(8'h02, seed);
    @(posedge clk_sys);
    alarm_in <= 7'h7F;
    stat = 'h7F;
    @(posedge clk_sys);
    alarm_in <= 7'h00;
    ichk();
    rd(8'h01, 8'h7F);
    stat = 0;
    for (int i = 0; i < NUM_SRC; i++) begin
      mask_m = 1 << i;
      acc(1'b1, 8'h00, 8'h01 << i);
      rd(8'h00, 8'h01 << i);
      @(posedge clk_sys);
      alarm_in <= 7'h01 << i;
      stat = 1 << i;
      ichk();
      @(posedge clk_sys);
      alarm_in <= 7'h00;
      rd(8'h01, 8'h01 << i);
      stat = 0;
      ichk();
    end
    mask_m = 'h7F;
    acc(1'b1, 8'h00, 8'h7F);
    acc(1'b1, 8'h80, 8'h05);
    stat = 'h05;
    ichk();
    acc(1'b1, 8'h80, 8'h00);
    rd(8'h01, 8'h05);
    rd(8'h01, 8'h00);
    stat = 0;
    ichk();
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    m_mask = RST_MASK;
    m_scratch = RST_SCRATCH;
    m_force = 0;
    @(negedge clk_sys);
    chk("scratch_out", scratch_out, RST_SCRATCH);
    rd(8'h00, RST_MASK);
    end_of_test();
  end
endmodule : host_register_port_tb
